/* include/dtp_pkg.sv */
// Functional notes
// - two limits compared separately: warning level and higher shutdown level
// - reaching the warning level raises the overtemperature warning event
// - reaching shutdown level holds the device in reset and requests OFF
// - after shutdown, power-on enables are blocked until below the warning level
// - both detections release only below their assertion level (hysteresis)
// - both detections are debounced before they take effect
// - warning level chosen from four settings in the thermal config register
// - protection on by default in ACTIVE; software may disable it
// - in SLEEP protection runs only when the keep-on retention bit is set
// - protection forced on during every OFF-to-ACTIVE transition
// - after thermal switch-off protection stays on through the OFF state
// - interrupt status flag records an OFF entry caused by thermal shutdown
// - from thermal OFF, switch-on starts once below the warning level
// - detection states readable and maskable in the thermal config register
// - warning interrupt suppressible by a bit of the interrupt mask register
// - warning event is a level, only generated in ACTIVE and SLEEP
package dtp_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] THERM_CFG_ADDR = 8'h38;
   localparam logic [7:0] SLEEP_RET_ADDR = 8'h42;
   localparam logic [7:0] INT_STS_ADDR = 8'h50;
   localparam logic [7:0] INT_MSK_ADDR = 8'h51;

   localparam logic [7:0] THERM_CFG_RST = 8'h0D;
   localparam logic [7:0] SLEEP_RET_RST = 8'h00;
   localparam logic [7:0] INT_STS_RST = 8'h00;
   localparam logic [7:0] INT_MSK_RST = 8'hFF;

   // thermal config fields
   localparam int CFG_EN_BIT = 0;
   localparam int CFG_SEL_LSB = 2;
   localparam int CFG_HD_MASK_BIT = 4;
   localparam int CFG_TS_MASK_BIT = 5;
   localparam int CFG_HD_STATE_BIT = 6;
   localparam int CFG_TS_STATE_BIT = 7;
   localparam logic [7:0] CFG_WR_MASK = 8'h3F;

   // retention, status and mask fields
   localparam int RET_THERM_BIT = 0;
   localparam int STS_HOT_BIT = 0;
   localparam int STS_TSD_BIT = 3;
   localparam logic [7:0] STS_IMPL_MASK = 8'h09;

   // ----------------------------------------------------------------
   // temperature codes
   // ----------------------------------------------------------------
   localparam logic [3:0][7:0] HD_THR = {8'h82, 8'h7D, 8'h78, 8'h73};
   localparam logic [7:0] TS_THR = 8'h96;
   localparam logic [7:0] HYST = 8'h05;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int DEB_TIME_NS = 10000;
   localparam int DEB_CYC = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [9:0] DEB_LAST = 10'(DEB_CYC - 1);

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      PWR_OFF = 2'b00,
      PWR_ACTIVE = 2'b01,
      PWR_SLEEP = 2'b10,
      PWR_OFF_TO_ACTIVE = 2'b11
   } dtp_pwr_t;

   typedef enum logic {
      PROT_RUN = 1'b0,
      PROT_SHUT = 1'b1
   } dtp_prot_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } dtp_bus_req_t;

   typedef struct packed {
      logic dev_reset;
      logic off_req;
      logic on_req;
      logic on_enable_block;
   } dtp_pwr_ctl_t;

   typedef struct packed {
      logic [9:0] cnt;
      logic level;
   } dtp_deb_st_t;

endpackage

/* verilog/dtp_debounce.sv */
`timescale 1ns/1ps
module dtp_debounce import dtp_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic raw,
   output logic level
);

   dtp_deb_st_t st;
   dtp_deb_st_t next_st;

   // ----------------------------------------------------------------
   // output follows raw only after it has differed for the full time
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      if (raw == st.level) begin
         next_st.cnt = '0;
      end else if (st.cnt == DEB_LAST) begin
         next_st.cnt = '0;
         next_st.level = raw;
      end else begin
         next_st.cnt = st.cnt + 10'h001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level = st.level;

endmodule

/* verilog/dtp_top.sv */
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module dtp_top import dtp_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire dtp_bus_req_t bus,
   output logic [7:0] rd_data,
   input wire logic [7:0] die_temp,
   input wire dtp_pwr_t pwr_state,
   output dtp_pwr_ctl_t pwr_ctl,
   output logic warn_level,
   output logic prot_active,
   output logic irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      dtp_prot_t prot;
      logic [7:0] cfg;
      logic [7:0] ret;
      logic [7:0] sts;
      logic [7:0] msk;
      logic [7:0] rdata;
      dtp_pwr_ctl_t ctl;
      logic warn;
      logic active;
      logic irq;
   } dtp_st_t;

   dtp_st_t st;
   dtp_st_t next_st;

   // ----------------------------------------------------------------
   // comparison with hysteresis and debounce
   // ----------------------------------------------------------------
   logic [1:0][7:0] thr_hi;
   logic [1:0][7:0] thr_lo;
   logic [1:0] cmp_raw;
   logic [1:0] det;

   always_comb begin
      thr_hi[0] = HD_THR[st.cfg[CFG_SEL_LSB +: 2]];
      thr_hi[1] = TS_THR;
      thr_lo[0] = thr_hi[0] - HYST;
      thr_lo[1] = thr_hi[1] - HYST;
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_det
         // release threshold drops once the detection is asserted
         assign cmp_raw[ch] = det[ch] ? (die_temp >= thr_lo[ch])
                                      : (die_temp >= thr_hi[ch]);
         dtp_debounce u_deb (
            .ref_clk(ref_clk),
            .rst(rst),
            .raw(cmp_raw[ch]),
            .level(det[ch])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // enable and effective detections
   // ----------------------------------------------------------------
   logic forced_on;
   logic prot_en;
   logic run_state;
   logic hd_eff;
   logic ts_eff;

   always_comb begin
      forced_on = (pwr_state == PWR_OFF_TO_ACTIVE)
                  || (st.prot == PROT_SHUT);
      run_state = (pwr_state == PWR_ACTIVE) || (pwr_state == PWR_SLEEP);
      prot_en = forced_on;
      if ((pwr_state == PWR_ACTIVE) && st.cfg[CFG_EN_BIT]) begin
         prot_en = 1'b1;
      end
      if ((pwr_state == PWR_SLEEP) && st.ret[RET_THERM_BIT]) begin
         prot_en = 1'b1;
      end
      hd_eff = prot_en && det[0] && !st.cfg[CFG_HD_MASK_BIT];
      ts_eff = prot_en && det[1]
               && (!st.cfg[CFG_TS_MASK_BIT] || forced_on);
   end

   // ----------------------------------------------------------------
   // register decode helpers
   // ----------------------------------------------------------------
   logic wr_cfg;
   logic wr_ret;
   logic wr_sts;
   logic wr_msk;

   always_comb begin
      wr_cfg = bus.we && (bus.addr == THERM_CFG_ADDR);
      wr_ret = bus.we && (bus.addr == SLEEP_RET_ADDR);
      wr_sts = bus.we && (bus.addr == INT_STS_ADDR);
      wr_msk = bus.we && (bus.addr == INT_MSK_ADDR);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic [7:0] sts_set;
   logic [7:0] sts_clr;
   logic [7:0] cfg_view;

   always_comb begin
      next_st = st;
      sts_set = 8'h00;
      sts_clr = 8'h00;
      next_st.ctl.off_req = 1'b0;
      next_st.ctl.on_req = 1'b0;

      // protection sequence
      unique case (st.prot)
         PROT_RUN: begin
            if (ts_eff && (pwr_state != PWR_OFF)) begin
               next_st.prot = PROT_SHUT;
               next_st.ctl.off_req = 1'b1;
               sts_set[STS_TSD_BIT] = 1'b1;
            end
         end
         PROT_SHUT: begin
            if (!det[0]) begin
               next_st.prot = PROT_RUN;
               next_st.ctl.on_req = 1'b1;
            end
         end
      endcase

      // held in reset and power-on enables ignored while shut down
      next_st.ctl.dev_reset = (next_st.prot == PROT_SHUT);
      next_st.ctl.on_enable_block = (next_st.prot == PROT_SHUT);

      // warning event: level, only in ACTIVE and SLEEP
      next_st.warn = hd_eff && run_state;
      if (hd_eff && run_state) begin
         sts_set[STS_HOT_BIT] = 1'b1;
      end

      next_st.active = prot_en;

      // register writes
      if (wr_cfg) begin
         next_st.cfg = bus.wdata & CFG_WR_MASK;
      end
      if (wr_ret) begin
         next_st.ret = bus.wdata;
      end
      if (wr_msk) begin
         next_st.msk = bus.wdata;
      end
      if (wr_sts) begin
         sts_clr = bus.wdata & STS_IMPL_MASK;
      end

      // set wins over a write-one clear
      next_st.sts = ((st.sts & ~sts_clr) | sts_set) & STS_IMPL_MASK;

      // interrupt follows the registered status and mask
      next_st.irq = |(next_st.sts & ~next_st.msk & STS_IMPL_MASK);

      // read path, data valid the cycle after the strobe only
      cfg_view = st.cfg & CFG_WR_MASK;
      cfg_view[CFG_HD_STATE_BIT] = det[0];
      cfg_view[CFG_TS_STATE_BIT] = det[1];
      next_st.rdata = 8'h00;
      if (bus.re) begin
         unique case (bus.addr)
            THERM_CFG_ADDR: begin
               next_st.rdata = cfg_view;
            end
            SLEEP_RET_ADDR: begin
               next_st.rdata = st.ret;
            end
            INT_STS_ADDR: begin
               next_st.rdata = st.sts;
            end
            INT_MSK_ADDR: begin
               next_st.rdata = st.msk;
            end
            default: begin
               next_st.rdata = 8'h00;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st.prot <= PROT_RUN;
         st.cfg <= THERM_CFG_RST & CFG_WR_MASK;
         st.ret <= SLEEP_RET_RST;
         st.sts <= INT_STS_RST;
         st.msk <= INT_MSK_RST;
         st.rdata <= 8'h00;
         st.ctl <= '0;
         st.warn <= 1'b0;
         st.active <= 1'b0;
         st.irq <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rd_data = st.rdata;
   assign pwr_ctl = st.ctl;
   assign warn_level = st.warn;
   assign prot_active = st.active;
   assign irq = st.irq;

endmodule

/* tb/dtp_chk.sv */
`timescale 1ns/1ps
module dtp_chk import dtp_pkg::*; (
   input wire logic ref_clk,
   input wire logic rst,
   input wire dtp_bus_req_t bus,
   input wire logic [7:0] rd_data,
   input wire logic [7:0] die_temp,
   input wire dtp_pwr_t pwr_state,
   input wire dtp_pwr_ctl_t pwr_ctl,
   input wire logic warn_level,
   input wire logic prot_active,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // --------
   // port relations
   // --------
   chk_rd_idle_zero: assert property (!$past(bus.re) |-> rd_data == 8'h00)
      else $error("read data outside read slot");
   chk_off_one_pulse: assert property (pwr_ctl.off_req |=> !pwr_ctl.off_req)
      else $error("off request longer than one cycle");
   chk_off_with_reset: assert property ($rose(pwr_ctl.dev_reset) |-> pwr_ctl.off_req)
      else $error("shutdown without off request");
   chk_block_tracks: assert property (pwr_ctl.dev_reset == pwr_ctl.on_enable_block)
      else $error("enable block differs from shutdown");
   chk_on_at_release: assert property ($fell(pwr_ctl.dev_reset) |-> pwr_ctl.on_req)
      else $error("release without switch-on");
   chk_forced_on: assert property ((pwr_state == PWR_OFF_TO_ACTIVE)[*2] |-> prot_active)
      else $error("protection off during switch-on");
   chk_shut_kept: assert property (pwr_ctl.dev_reset && $past(pwr_ctl.dev_reset)
      |-> prot_active)
      else $error("protection off in thermal off");
   chk_block_release: assert property ($fell(pwr_ctl.on_enable_block)
      |-> $past(die_temp, 2) < HD_THR[3] - HYST)
      else $error("enable block released while hot");
   chk_warn_off_state: assert property ((pwr_state == PWR_OFF)[*2] |-> !warn_level)
      else $error("warning in off state");
   chk_irq_masked: assert property (bus.we && bus.addr == INT_MSK_ADDR
      && bus.wdata == 8'hFF |=> !irq)
      else $error("irq with all masked");
   cov_off: cover property (pwr_ctl.off_req);
   cov_on: cover property (pwr_ctl.on_req);
   cov_warn: cover property (warn_level && irq);
endmodule

/* tb/dtp_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
   $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module dtp_bench import dtp_pkg::*;;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   dtp_bus_req_t bus = '0;
   logic [7:0] rd_data;
   logic [7:0] die_temp = 8'h40;
   dtp_pwr_t pwr_state = PWR_ACTIVE;
   dtp_pwr_ctl_t pwr_ctl;
   logic warn_level;
   logic prot_active;
   logic irq;
   int err_count = 0;
   int n_compared = 0;
   always #5 ref_clk = ~ref_clk;
   dtp_top dtp_top_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
      .die_temp(die_temp), .pwr_state(pwr_state), .pwr_ctl(pwr_ctl),
      .warn_level(warn_level), .prot_active(prot_active), .irq(irq));
   // --------
   // bus and stimulus helpers
   // --------
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
      @(posedge ref_clk);
      bus.we <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge ref_clk);
      bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge ref_clk);
      bus.re <= 1'b0;
      #1;
      `CHK("rd_data", exp, rd_data)
   endtask
   task automatic heat(input logic [7:0] t, input int n);
      @(posedge ref_clk);
      die_temp <= t;
      cyc(n);
   endtask
   task automatic pwr(input dtp_pwr_t p);
      @(posedge ref_clk);
      pwr_state <= p;
      cyc(2);
   endtask
   // --------
   // scenarios
   // --------
   task automatic t_reset;
      rd(THERM_CFG_ADDR, THERM_CFG_RST);
      rd(SLEEP_RET_ADDR, SLEEP_RET_RST);
      rd(INT_STS_ADDR, INT_STS_RST);
      rd(INT_MSK_ADDR, INT_MSK_RST);
      wr(8'h3A, 8'h55);
      rd(8'h3A, 8'h00);
      `CHK("prot", 1'b1, prot_active)
      $display("test reset done");
   endtask
   task automatic t_enable;
      wr(THERM_CFG_ADDR, 8'h0C);
      cyc(1);
      `CHK("act_off", 1'b0, prot_active)
      pwr(PWR_OFF_TO_ACTIVE);
      `CHK("forced", 1'b1, prot_active)
      pwr(PWR_SLEEP);
      `CHK("slp_off", 1'b0, prot_active)
      wr(SLEEP_RET_ADDR, 8'h01);
      cyc(1);
      `CHK("slp_on", 1'b1, prot_active)
      pwr(PWR_OFF);
      `CHK("off", 1'b0, prot_active)
      pwr(PWR_ACTIVE);
      $display("test enable done");
   endtask
   task automatic t_warn;
      logic [7:0] th;
      wr(INT_MSK_ADDR, 8'hFE);
      for (int s = 0; s < 4; s++) begin
         th = HD_THR[s];
         wr(THERM_CFG_ADDR, {4'h0, 2'(s), 2'b01});
         heat(th, 990);
         heat(th - 8'h01, 1010);
         `CHK("blip", 1'b0, warn_level)
         heat(th, 1010);
         `CHK("warn", 1'b1, warn_level)
         `CHK("irq", 1'b1, irq)
         rd(THERM_CFG_ADDR, {2'b01, 2'b00, 2'(s), 2'b01});
         heat(th - HYST, 1010);
         `CHK("hyst", 1'b1, warn_level)
         heat(th - HYST - 8'h01, 1010);
         `CHK("release", 1'b0, warn_level)
         wr(INT_MSK_ADDR, 8'hFF);
         `CHK("masked", 1'b0, irq)
         wr(INT_MSK_ADDR, 8'hFE);
         rd(INT_STS_ADDR, 8'h01);
         wr(INT_STS_ADDR, 8'h01);
         `CHK("cleared", 1'b0, irq)
      end
      wr(THERM_CFG_ADDR, 8'h3D);
      heat(TS_THR, 1010);
      `CHK("hd_masked", 1'b0, warn_level)
      `CHK("ts_masked", 1'b0, pwr_ctl.dev_reset)
      rd(THERM_CFG_ADDR, 8'hFD);
      rd(INT_STS_ADDR, 8'h00);
      heat(8'h40, 1010);
      wr(THERM_CFG_ADDR, 8'h0D);
      $display("test warn done");
   endtask
   task automatic t_shut;
      int k;
      wr(INT_MSK_ADDR, 8'hF7);
      heat(TS_THR, 1000);
      `CHK("pre_shut", 1'b0, pwr_ctl.dev_reset)
      cyc(1);
      `CHK("off_req", 1'b1, pwr_ctl.off_req)
      `CHK("dev_reset", 1'b1, pwr_ctl.dev_reset)
      `CHK("irq", 1'b1, irq)
      cyc(1);
      `CHK("off_pulse", 1'b0, pwr_ctl.off_req)
      rd(INT_STS_ADDR, 8'h09);
      pwr(PWR_OFF);
      heat(8'h7E, 1010);
      `CHK("blocked", 1'b1, pwr_ctl.on_enable_block)
      `CHK("kept", 1'b1, prot_active)
      `CHK("no_warn", 1'b0, warn_level)
      @(posedge ref_clk);
      die_temp <= 8'h7C;
      k = 0;
      while (pwr_ctl.on_req !== 1'b1 && k < 1100) begin
         cyc(1);
         k++;
      end
      `CHK("on_req", 1'b1, pwr_ctl.on_req)
      `CHK("released", 1'b0, pwr_ctl.dev_reset)
      pwr(PWR_ACTIVE);
      rd(INT_STS_ADDR, 8'h09);
      wr(INT_STS_ADDR, 8'h09);
      rd(INT_STS_ADDR, 8'h00);
      $display("test shutdown done");
   endtask
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset();
      t_enable();
      t_warn();
      t_shut();
      test_done();
   end
   initial begin
      #400000;
      err_count++;
      test_done();
   end
endmodule
bind dtp_top dtp_chk dtp_chk_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus), .rd_data(rd_data),
   .die_temp(die_temp), .pwr_state(pwr_state), .pwr_ctl(pwr_ctl), .warn_level(warn_level),
   .prot_active(prot_active), .irq(irq));
